// ---- verilog/sdc_pkg.sv ----
// shared constants for the daisy-chain serial register port
// assumes both ends and the bench compile this package first

package sdc_pkg;

   // ***********************************************************
   // frame layout and register store
   // ***********************************************************
   localparam int FRAME_BITS = 16;
   localparam int ADDR_W     = 7;
   localparam int DATA_W     = 8;
   localparam int CMD_POS    = 15;
   localparam int ADDR_MSB   = 14;
   localparam int ADDR_LSB   = 8;
   localparam int DATA_MSB   = 7;
   localparam int DATA_LSB   = 0;
   localparam logic CMD_WR   = 1'b0;
   localparam logic CMD_RD   = 1'b1;
   localparam int NUM_REGS   = 128;
   localparam logic [7:0] REG_RST = 8'h00;

   // edge of a transaction at which read data is spliced in
   localparam logic [1:0] SPLICE_EDGE = 2'h2;

   // ***********************************************************
   // host timing and frame queue
   // ***********************************************************
   localparam int REF_PERIOD_NS = 8;
   localparam int SCK_HALF_NS   = 24;
   localparam int SCK_HALF_CYC  = SCK_HALF_NS / REF_PERIOD_NS;
   localparam int SS_IDLE_NS    = 128;
   localparam int SS_IDLE_CYC   = (SS_IDLE_NS + REF_PERIOD_NS - 1)
                                  / REF_PERIOD_NS;
   localparam int FIFO_DEPTH    = 16;
   localparam int FIFO_W        = FRAME_BITS + 1;

endpackage

// ---- verilog/sdc_spi_if.sv ----
// the serial link between host end and device end
// assumes the bench joins further devices by chaining miso to mosi
`timescale 1ns/1ps

interface sdc_spi_if;
   logic sck;       // link clock, made by the host
   logic ss_n;      // frame select, active low
   logic mosi;      // host to device data
   logic miso;      // device data drive
   logic miso_oe;   // device drives miso while high
   logic miso_pin;  // resolved line level

   // undriven line reads as a pulled-up one
   assign miso_pin = miso_oe ? miso : 1'b1;

   modport host (output sck, output ss_n, output mosi, input miso_pin);
   modport dev  (input sck, input ss_n, input mosi,
                 output miso, output miso_oe);
endinterface

// ---- verilog/sdc_fifo.sv ----
// synchronous valid/ready fifo with full and empty from registers
// assumes one clock and the active-low async reset
`timescale 1ns/1ps

module sdc_fifo #(
   parameter int W = 17,
   parameter int D = 16
) (
   input  wire logic         ref_clk,
   input  wire logic         nrst,
   input  wire logic         in_valid,
   output      logic         in_ready,
   input  wire logic [W-1:0] in_data,
   output      logic         out_valid,
   input  wire logic         out_ready,
   output      logic [W-1:0] out_data
);
   localparam int PW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [PW-1:0]       wp;
      logic [PW-1:0]       rp;
      logic [PW:0]         cnt;
      logic                rdy;
      logic                vld;
   } sdc_fifo_s;

   sdc_fifo_s r, n;
   logic      push;
   logic      pop;

   // ***********************************************************
   // next state
   // ***********************************************************
   // full and empty come from flops so ready never glitches
   always_comb
   begin
      n    = r;
      push = in_valid && r.rdy;
      pop  = out_ready && r.vld;
      if (push)
      begin
         n.mem[r.wp] = in_data;
         n.wp        = PW'(r.wp + 1'b1);
      end
      if (pop)
         n.rp = PW'(r.rp + 1'b1);
      n.cnt = (PW+1)'(r.cnt + push - pop);
      n.rdy = n.cnt != (PW+1)'(D);
      n.vld = n.cnt != '0;
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         r     <= '0;
         r.rdy <= 1'b1;
      end
      else
         r <= n;
   end

   assign in_ready  = r.rdy;
   assign out_valid = r.vld;
   assign out_data  = r.mem[r.rp];
endmodule

// ---- verilog/sdc_dev_end.sv ----
// device end of the daisy-chain serial register port: one 16-bit
// shift stage plus the register store behind it
// assumes the host keeps sck low while ss_n is high and keeps
// ss_n high for several ref_clk cycles between transactions
//
// What this block does
// - host gives sixteen edges per device, select low
// - host sends farthest device's write frame first
// - write frame: zero, seven-bit address, data byte
// - writes take effect when select rises
// - read frame: one, address, eight ignored ones
// - read frames ordered farthest device first
// - select rise latches reads, then all-ones pass
// - read data returns farthest device first
// - sample rising, update falling, msb first
// - previous frame shifts out as new shifts in
// - miso driven only while select is low
// - read byte fills second half of frame
`timescale 1ns/1ps

module sdc_dev_end (
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   sdc_spi_if.dev           link,
   output      logic        upd_stb,
   output      logic [6:0]  upd_addr,
   output      logic [7:0]  upd_data
);

   // ***********************************************************
   // state of each domain
   // ***********************************************************
   // link side, rising sck
   typedef struct packed {
      logic [15:0] sh;      // the shift stage
      logic        tog_s1;  // read-ready toggle, first stage
      logic        tog_s2;  // read-ready toggle, second stage
      logic        ack;     // last toggle consumed
   } sdc_rise_s;

   // reference side
   typedef struct packed {
      logic [127:0][7:0] regs;
      logic              ss_s1;
      logic              ss_s2;
      logic              ss_d;
      logic [7:0]        rd_byte;
      logic              tog;
      logic              stb;
      logic [6:0]        addr;
      logic [7:0]        data;
   } sdc_ref_s;

   sdc_rise_s   rr, rn;
   sdc_ref_s    fr, fn;
   logic [1:0]  edge_r;
   logic [1:0]  edge_nxt;
   logic        miso_r;
   logic [15:0] frame_w;
   logic [6:0]  fr_addr;
   logic [7:0]  fr_data;

   // ***********************************************************
   // edge counter of the current transaction
   // ***********************************************************
   // cleared by select itself since sck stands still between
   // transactions; saturates once the splice point has passed
   always_comb
   begin
      edge_nxt = edge_r;
      if (edge_r != 2'h3)
         edge_nxt = 2'(edge_r + 2'h1);
   end

   always_ff @(posedge link.sck or posedge link.ss_n)
   begin
      if (link.ss_n)
         edge_r <= 2'h0;
      else
         edge_r <= edge_nxt;
   end

   // ***********************************************************
   // shift stage
   // ***********************************************************
   // mosi enters at the bottom on each rising edge; when a read
   // was latched, its byte replaces the held data byte early in
   // the next transaction, before any of it reaches the top
   always_comb
   begin
      rn        = rr;
      rn.tog_s1 = fr.tog;
      rn.tog_s2 = rr.tog_s1;
      rn.sh     = {rr.sh[14:0], link.mosi};
      if (edge_r == sdc_pkg::SPLICE_EDGE && rr.tog_s2 != rr.ack)
      begin
         // two shifts have moved the data byte up to [9:2]
         rn.sh  = {rr.sh[14:10], fr.rd_byte,
                   rr.sh[1:0], link.mosi};
         rn.ack = rr.tog_s2;
      end
   end

   always_ff @(posedge link.sck or negedge nrst)
   begin
      if (!nrst)
         rr <= '0;
      else
         rr <= rn;
   end

   // ***********************************************************
   // serial output
   // ***********************************************************
   // the top bit moves out on the falling edge, so a chained
   // device samples it half a period later
   always_ff @(negedge link.sck or negedge nrst)
   begin
      if (!nrst)
         miso_r <= 1'b0;
      else
         miso_r <= rr.sh[sdc_pkg::CMD_POS];
   end

   assign link.miso    = miso_r;
   // follows select directly; a flop here would miss the first bit
   assign link.miso_oe = !link.ss_n;

   // ***********************************************************
   // commit on select rising
   // ***********************************************************
   // the shift stage is read only after select has risen and been
   // synchronised; sck is idle then, so the word is quasi-static
   assign frame_w = rr.sh;
   assign fr_addr = frame_w[sdc_pkg::ADDR_MSB:sdc_pkg::ADDR_LSB];
   assign fr_data = frame_w[sdc_pkg::DATA_MSB:sdc_pkg::DATA_LSB];

   always_comb
   begin
      fn       = fr;
      fn.stb   = 1'b0;
      fn.ss_s1 = link.ss_n;
      fn.ss_s2 = fr.ss_s1;
      fn.ss_d  = fr.ss_s2;
      if (fr.ss_s2 && !fr.ss_d)
      begin
         if (frame_w[sdc_pkg::CMD_POS] == sdc_pkg::CMD_WR)
         begin
            // write: command low, address, then data
            fn.regs[fr_addr] = fr_data;
            fn.stb           = 1'b1;
            fn.addr          = fr_addr;
            fn.data          = fr_data;
         end
         else
         begin
            // read: low byte of the request is ignored
            fn.rd_byte = fr.regs[fr_addr];
            fn.tog     = !fr.tog;
         end
      end
   end

   // idle select level is high, so the synchronisers reset high
   // to avoid a false commit straight after reset
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         fr       <= '0;
         fr.regs  <= {sdc_pkg::NUM_REGS{sdc_pkg::REG_RST}};
         fr.ss_s1 <= 1'b1;
         fr.ss_s2 <= 1'b1;
         fr.ss_d  <= 1'b1;
      end
      else
         fr <= fn;
   end

   // ***********************************************************
   // user side
   // ***********************************************************
   // one pulse per applied write, for the logic the registers steer
   assign upd_stb  = fr.stb;
   assign upd_addr = fr.addr;
   assign upd_data = fr.data;

endmodule

// ---- verilog/sdc_host_end.sv ----
// host end: takes 16-bit frames from the user through a fifo and
// drives them out on the link, returning what comes back
// assumes the user pushes frames in chain order and marks the last
// frame of each transaction
`timescale 1ns/1ps

module sdc_host_end (
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   sdc_spi_if.host          link,
   input  wire logic        tx_valid,
   output      logic        tx_ready,
   input  wire logic [15:0] tx_data,
   input  wire logic        tx_last,
   output      logic        rx_valid,
   output      logic [15:0] rx_data
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SETUP,
      ST_SHIFT,
      ST_GAP
   } sdc_host_e;

   typedef struct packed {
      sdc_host_e   st;
      logic [4:0]  cnt;    // half-period or gap counter
      logic [3:0]  bit_i;
      logic [16:0] word;   // {last, frame}
      logic [15:0] rx;
      logic        miso_s1;
      logic        miso_s2;
      logic        sck;
      logic        ss_n;
      logic        mosi;
      logic        pop;
      logic        rx_valid;
      logic [15:0] rx_data;
   } sdc_host_s;

   localparam logic [4:0] HALF_END = 5'(sdc_pkg::SCK_HALF_CYC - 1);
   localparam logic [4:0] GAP_END  = 5'(sdc_pkg::SS_IDLE_CYC - 1);

   sdc_host_s   r, n;
   logic        q_valid;
   logic [16:0] q_data;

   // ***********************************************************
   // frame queue
   // ***********************************************************
   // the link is far slower than the user side, so this fills
   sdc_fifo #(
      .W (sdc_pkg::FIFO_W),
      .D (sdc_pkg::FIFO_DEPTH)
   ) u_q (
      .ref_clk   (ref_clk),
      .nrst      (nrst),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .in_data   ({tx_last, tx_data}),
      .out_valid (q_valid),
      .out_ready (r.pop),
      .out_data  (q_data)
   );

   // ***********************************************************
   // link sequencer
   // ***********************************************************
   // pop is a registered pulse; the entry taken is the head still
   // shown while it is high, so it is never taken twice
   always_comb
   begin
      n          = r;
      n.pop      = 1'b0;
      n.rx_valid = 1'b0;
      n.miso_s1  = link.miso_pin;
      n.miso_s2  = r.miso_s1;
      n.cnt      = 5'(r.cnt + 5'h1);
      case (r.st)
         ST_IDLE, ST_SETUP:
         begin
            if (r.st == ST_SETUP && r.cnt == HALF_END)
            begin
               n.st  = ST_SHIFT;
               n.cnt = 5'h0;
            end
            else if (r.st == ST_IDLE && q_valid && !r.pop)
            begin
               n.word  = q_data;
               n.pop   = 1'b1;
               n.ss_n  = 1'b0;
               n.mosi  = q_data[sdc_pkg::CMD_POS];
               n.bit_i = 4'h0;
               n.cnt   = 5'h0;
               n.st    = ST_SETUP;
            end
         end
         ST_SHIFT:
         begin
            if (r.cnt == HALF_END)
            begin
               n.cnt = 5'h0;
               n.sck = !r.sck;
               if (!r.sck)
                  n.rx = {r.rx[14:0], r.miso_s2};
               else if (r.bit_i == 4'hf)
               begin
                  // frame done; frames go out in queue order
                  n.rx_valid = 1'b1;
                  n.rx_data  = r.rx;
                  n.st       = r.word[16] ? ST_GAP : ST_IDLE;
                  n.ss_n     = r.word[16];
               end
               else
               begin
                  n.bit_i = 4'(r.bit_i + 4'h1);
                  n.word  = {r.word[16], r.word[14:0], 1'b0};
                  n.mosi  = r.word[14];
               end
            end
         end
         ST_GAP:
         begin
            // select stays high long enough for devices to commit
            if (r.cnt == GAP_END)
               n.st = ST_IDLE;
         end
         default:
            n.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         r      <= '0;
         r.st   <= ST_IDLE;
         r.ss_n <= 1'b1;
      end
      else
         r <= n;
   end

   assign link.sck  = r.sck;
   assign link.ss_n = r.ss_n;
   assign link.mosi = r.mosi;
   assign rx_valid  = r.rx_valid;
   assign rx_data   = r.rx_data;
endmodule

// ---- bench/sdc_link_monitor.sv ----
// link checker: watches select, clock and data of one link
// assumes a single device sits on the watched link
`timescale 1ns/1ps

module sdc_link_monitor (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic sck,
   input wire logic ss_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic miso_pin
);
   // ******
   // shadow of the shift stage and register store
   // ******
   logic [3:0]  idx_r;
   logic [15:0] cur_r;
   logic [15:0] prev_r;
   logic        have_r;
   logic [7:0]  mem_r [128];
   logic [7:0]  rbyte_r;

   // the index wraps every sixteen edges, so a short frame shows up
   always_ff @(posedge sck or negedge nrst)
   begin
      if (!nrst)
      begin
         idx_r  <= 4'h0;
         cur_r  <= 16'h0000;
         prev_r <= 16'h0000;
         have_r <= 1'b0;
      end
      else
      begin
         idx_r <= idx_r + 4'h1;
         cur_r <= {cur_r[14:0], mosi};
         if (idx_r == 4'hf)
         begin
            prev_r <= {cur_r[14:0], mosi};
            have_r <= 1'b1;
         end
      end
   end

   // commit on select rising, as the device must
   always_ff @(posedge ss_n or negedge nrst)
   begin
      if (!nrst)
      begin
         rbyte_r <= sdc_pkg::REG_RST;
         for (int i = 0; i < 128; i++)
            mem_r[i] <= sdc_pkg::REG_RST;
      end
      else
      begin
         rbyte_r <= mem_r[prev_r[14:8]];
         if (prev_r[15] == sdc_pkg::CMD_WR)
            mem_r[prev_r[14:8]] <= prev_r[7:0];
      end
   end

   // ******
   // assertions
   // ******
   sequence s_ss_rise;
      $rose(ss_n);
   endsequence

   sequence s_quiet;
      ss_n && !sck;
   endsequence

   AST_OE_SEL:
   assert property (@(posedge ref_clk) disable iff (!nrst)
      !ss_n |-> miso_oe && miso_pin == miso)
      else $error("miso not driven while selected");
   AST_PIN_IDLE:
   assert property (@(posedge ref_clk) disable iff (!nrst)
      ss_n |-> !miso_oe && miso_pin)
      else $error("miso driven while deselected");
   AST_MISO_FALL:
   assert property (@(posedge ref_clk) disable iff (!nrst)
      !ss_n && !$past(ss_n) && $changed(miso) |-> $fell(sck))
      else $error("miso changed away from a falling clock");
   AST_SHIFT_OUT:
   assert property (@(posedge sck) disable iff (!nrst)
      have_r && (idx_r < 4'h8 || prev_r[15] == sdc_pkg::CMD_WR)
      |-> miso == prev_r[4'hf - idx_r])
      else $error("miso differs from the held frame");
   AST_READ_BYTE:
   assert property (@(posedge sck) disable iff (!nrst)
      have_r && idx_r >= 4'h8 && prev_r[15] == sdc_pkg::CMD_RD
      |-> miso == rbyte_r[3'(4'hf - idx_r)])
      else $error("read byte wrong in second half");
   AST_SCK_IDLE:
   assert property (@(posedge ref_clk) disable iff (!nrst)
      ss_n |-> !sck)
      else $error("clock toggles outside a transaction");
   AST_SS_GAP:
   assert property (@(posedge ref_clk) disable iff (!nrst)
      s_ss_rise |-> s_quiet [*8])
      else $error("select high gap too short");
   AST_FRAME_LEN:
   assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(ss_n) |-> idx_r == 4'h0)
      else $error("transaction not a whole number of frames");
endmodule

// ---- bench/testbench.sv ----
// self-checking bench: host end drives one device end over the link
// assumes the package, interface, fifo and both ends compile first
`timescale 1ns/1ps

module testbench;
   logic        ref_clk;
   logic        nrst;
   logic        tx_valid;
   logic        tx_ready;
   logic [15:0] tx_data;
   logic        tx_last;
   logic        rx_valid;
   logic [15:0] rx_data;
   logic        upd_stb;
   logic [6:0]  upd_addr;
   logic [7:0]  upd_data;
   logic [15:0] rxq [$];
   logic [14:0] updq [$];
   logic [15:0] fr [$];
   logic [7:0]  shadow [128];
   logic [15:0] last_fr;
   logic        have_last;
   logic        full_seen;
   int          fail_count;
   int          num_checks;
   int          cyc;

   sdc_spi_if link ();

   sdc_host_end u_sdc_host_end (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .link     (link),
      .tx_valid (tx_valid),
      .tx_ready (tx_ready),
      .tx_data  (tx_data),
      .tx_last  (tx_last),
      .rx_valid (rx_valid),
      .rx_data  (rx_data)
   );

   sdc_dev_end u_sdc_dev_end (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .link     (link),
      .upd_stb  (upd_stb),
      .upd_addr (upd_addr),
      .upd_data (upd_data)
   );

   sdc_link_monitor u_mon (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .sck      (link.sck),
      .ss_n     (link.ss_n),
      .mosi     (link.mosi),
      .miso     (link.miso),
      .miso_oe  (link.miso_oe),
      .miso_pin (link.miso_pin)
   );

   // ******
   // clock, timeout and collectors
   // ******
   always #4 ref_clk = ~ref_clk;

   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         stop_test();
      end
   end

   // updates must only land once select is back high
   always @(posedge ref_clk)
   begin
      if (rx_valid === 1'b1)
         rxq.push_back(rx_data);
      if (tx_ready === 1'b0)
         full_seen = 1'b1;
      if (upd_stb === 1'b1)
      begin
         updq.push_back({upd_addr, upd_data});
         check("select at commit", {15'h0, link.ss_n}, 16'h1);
      end
   end

   // ******
   // tasks
   // ******
   task automatic check(input string what, input logic [15:0] got,
                        input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // holds valid up between back-to-back pushes, re-assigning it on each push
   task automatic push(input logic [15:0] d);
      tx_valid <= 1'b1;
      tx_data  <= d;
      tx_last  <= 1'b1;
      do
         @(posedge ref_clk);
      while (tx_ready !== 1'b1);
   endtask

   // expected frame back: the previous one, read byte spliced in
   function automatic logic [15:0] step(input logic [15:0] d);
      logic [15:0] e;
      e = last_fr;
      if (last_fr[15] == sdc_pkg::CMD_RD)
         e[7:0] = shadow[last_fr[14:8]];
      if (d[15] == sdc_pkg::CMD_WR)
         shadow[d[14:8]] = d[7:0];
      last_fr = d;
      return e;
   endfunction

   // one frame per transaction; the whole list is pushed first, waiting while the fifo is full
   task automatic run();
      logic [15:0] got;
      logic [15:0] e;
      foreach (fr[i])
         push(fr[i]);
      tx_valid <= 1'b0;
      foreach (fr[i])
      begin
         for (int k = 0; k < 600 && rxq.size() == 0; k++)
            @(posedge ref_clk);
         got = (rxq.size() > 0) ? rxq.pop_front() : 16'hxxxx;
         e = step(fr[i]);
         if (have_last)
            check("returned frame", got, e);
         have_last = 1'b1;
      end
      repeat (8) @(posedge ref_clk);
      foreach (fr[i])
         if (fr[i][15] == sdc_pkg::CMD_WR)
         begin
            got = (updq.size() > 0) ? {1'b0, updq.pop_front()} : 16'hffff;
            check("update", got, {1'b0, fr[i][14:0]});
         end
      check("extra updates", 16'(updq.size()), 16'h0000);
      fr.delete();
   endtask

   // ******
   // main sequence
   // ******
   initial
   begin
      ref_clk   = 1'b0;
      nrst      = 1'b0;
      tx_valid  = 1'b0;
      tx_data   = 16'h0000;
      tx_last   = 1'b0;
      have_last = 1'b0;
      full_seen = 1'b0;
      last_fr   = 16'h0000;
      foreach (shadow[i])
         shadow[i] = sdc_pkg::REG_RST;
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      // writes at both address ends, reads with dummy passes after
      // frames go in chain order, farthest device first
      fr = '{16'h005a, 16'h7fc3, 16'h2a01, 16'h80ff, 16'hffff,
             16'haaff, 16'hffff, 16'h91ff, 16'hffff, 16'h1099,
             16'h90ff, 16'hffff};
      run();
      // overfill the fifo so it refuses, then drain it empty
      for (int i = 0; i < 18; i++)
         fr.push_back({8'h03, 8'(i * 17)});
      fr.push_back(16'h83ff);
      fr.push_back(16'hffff);
      run();
      check("fifo refused", {15'h0, full_seen}, 16'h0001);
      check("fifo drained", {15'h0, tx_ready}, 16'h0001);
      stop_test();
   end
endmodule
